// file: rtl/cco_pkg.sv
// constants, register map and carrier types for the communication-object bank
// assumes one 100 MHz clock and an APB master with 32-bit data on the far side
package cco_pkg;

  // register indices; byte address is four times the index
  localparam logic [17:0] CCO_IDX_HB_PERIOD = 18'h01017;
  localparam logic [17:0] CCO_IDX_SYNC_WRAP = 18'h01019;
  localparam logic [17:0] CCO_IDX_ID_COUNT = 18'h01100;
  localparam logic [17:0] CCO_IDX_MAKER = 18'h01101;
  localparam logic [17:0] CCO_IDX_PRODUCT = 18'h01102;
  localparam logic [17:0] CCO_IDX_REVISION = 18'h01103;
  localparam logic [17:0] CCO_IDX_SERIAL = 18'h01104;
  localparam logic [17:0] CCO_IDX_VFY_COUNT = 18'h01120;
  localparam logic [17:0] CCO_IDX_CFG_DATE = 18'h01121;
  localparam logic [17:0] CCO_IDX_CFG_TIME = 18'h01122;
  localparam logic [17:0] CCO_IDX_GUARD_CTRL = 18'h01200;
  localparam logic [17:0] CCO_IDX_STATUS = 18'h01201;

  // reset values and fixed contents
  localparam logic [15:0] CCO_HB_RESET = 16'h0000;
  localparam logic [7:0] CCO_WRAP_RESET = 8'h00;
  localparam logic [7:0] CCO_WRAP_MIN = 8'h02;
  localparam logic [7:0] CCO_WRAP_MAX = 8'hF0;
  localparam logic [7:0] CCO_ID_ENTRIES = 8'h04;
  localparam logic [7:0] CCO_VFY_ENTRIES = 8'h02;
  localparam logic [31:0] CCO_WORD_RESET = 32'h00000000;
  // identity words: arbitrary neutral values
  localparam logic [31:0] CCO_MAKER_DEF = 32'h0000A5A1;
  localparam logic [31:0] CCO_PRODUCT_DEF = 32'h00000101;
  localparam logic [31:0] CCO_REVISION_DEF = 32'h00010000;
  localparam logic [31:0] CCO_SERIAL_DEF = 32'h00000000;

  // guard control fields: bit 16 enable, bits 15:0 guard time in ms
  localparam int CCO_GC_EN_BIT = 16;
  localparam logic [15:0] CCO_GUARD_RESET = 16'h0000;

  // status fields
  localparam int CCO_ST_HB_BIT = 8;
  localparam int CCO_ST_GUARD_BIT = 9;

  // timing
  localparam int CCO_CLK_PERIOD_NS = 10;
  localparam int CCO_MS_NS = 1000000;
  localparam int CCO_MS_CYCLES = CCO_MS_NS / CCO_CLK_PERIOD_NS;

  // apb carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
  } cco_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cco_apb_rsp_s;

endpackage : cco_pkg

// file: rtl/cco_interval_timer.sv
// millisecond interval timer: pulses once every period ticks
// assumes tick is a one-cycle enable on mclk; period zero holds it idle
`timescale 1ns/1ps
module cco_interval_timer
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic tick,
  input wire logic restart,
  input wire logic [15:0] period,
  // result
  output logic expire
);
  import cco_pkg::*;

  logic [15:0] count;

  // count ticks; a zero period parks the timer so nothing fires
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      count <= 16'h0000;
      expire <= 1'b0;
    end
    else if (restart || period == 16'h0000)
    begin
      count <= 16'h0000;
      expire <= 1'b0;
    end
    else if (tick)
    begin
      if (count + 16'h0001 >= period)
      begin
        count <= 16'h0000;
        expire <= 1'b1;
      end
      else
      begin
        count <= count + 16'h0001;
        expire <= 1'b0;
      end
    end
    else
    begin
      expire <= 1'b0;
    end
  end

endmodule : cco_interval_timer

// file: rtl/cco_comm_objects.sv
// communication-object bank: heartbeat producer timing, node guarding
// supervision, sync counter wrap, identity and configuration verify record
// assumes an APB master on mclk and protocol logic on mclk for the event inputs
`timescale 1ns/1ps
module cco_comm_objects
#(
  parameter int MS_CYCLES = cco_pkg::CCO_MS_CYCLES,
  parameter logic [31:0] MAKER_CODE = cco_pkg::CCO_MAKER_DEF,
  parameter logic [31:0] PRODUCT_CODE = cco_pkg::CCO_PRODUCT_DEF,
  parameter logic [31:0] REVISION_CODE = cco_pkg::CCO_REVISION_DEF,
  parameter logic [31:0] SERIAL_WORD = cco_pkg::CCO_SERIAL_DEF
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register bus
  input wire cco_pkg::cco_apb_req_s apbReq,
  output cco_pkg::cco_apb_rsp_s apbRsp,
  // protocol events
  input wire logic syncEvent,
  input wire logic guardRequest,
  // protocol requests and state
  output logic hbSend,
  output logic guardEmcy,
  output logic guardActive,
  output logic [7:0] syncCount
);
  import cco_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] heartbeatPeriod;
  logic [7:0] syncWrapValue;
  logic [31:0] storedConfigDate;
  logic [31:0] storedConfigTime;
  logic guardEnable;
  logic [15:0] guardTime;

  logic [17:0] regIndex;
  logic setupPhase;
  logic writeCommit;
  logic wrapLegal;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic hbRestart;
  logic hbActive;
  logic guardRun;
  logic [15:0] guardPeriod;
  logic msTick;
  logic [31:0] msCount;
  logic hbExpire;
  logic guardExpire;

  assign regIndex = apbReq.paddr[19:2];
  assign setupPhase = apbReq.psel && !apbReq.penable && !apbRsp.pready;
  // a write lands only at the edge where the access phase meets pready
  assign writeCommit = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
                       && !apbRsp.pslverr;
  // zero is kept legal so the reset value can be written back
  assign wrapLegal = (apbReq.pwdata[7:0] == CCO_WRAP_RESET)
                     || (apbReq.pwdata[7:0] >= CCO_WRAP_MIN && apbReq.pwdata[7:0] <= CCO_WRAP_MAX);

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: read data and error are settled in the setup cycle

  always_comb
  begin
    next_prdata = CCO_WORD_RESET;
    next_pslverr = 1'b0;
    unique case (regIndex)
      CCO_IDX_HB_PERIOD:
      begin
        next_prdata = {16'h0000, heartbeatPeriod};
      end
      CCO_IDX_SYNC_WRAP:
      begin
        next_prdata = {24'h000000, syncWrapValue};
        next_pslverr = apbReq.pwrite && !wrapLegal;
      end
      CCO_IDX_ID_COUNT:
      begin
        next_prdata = {24'h000000, CCO_ID_ENTRIES};
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_MAKER:
      begin
        next_prdata = MAKER_CODE;
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_PRODUCT:
      begin
        next_prdata = PRODUCT_CODE;
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_REVISION:
      begin
        next_prdata = REVISION_CODE;
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_SERIAL:
      begin
        next_prdata = SERIAL_WORD;
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_VFY_COUNT:
      begin
        next_prdata = {24'h000000, CCO_VFY_ENTRIES};
        next_pslverr = apbReq.pwrite;
      end
      CCO_IDX_CFG_DATE:
      begin
        next_prdata = storedConfigDate;
      end
      CCO_IDX_CFG_TIME:
      begin
        next_prdata = storedConfigTime;
      end
      CCO_IDX_GUARD_CTRL:
      begin
        next_prdata = {15'h0000, guardEnable, guardTime};
      end
      CCO_IDX_STATUS:
      begin
        next_prdata = {22'h000000, guardRun, hbActive, syncCount};
        next_pslverr = apbReq.pwrite;
      end
      default:
      begin
        // unmapped: reads zero and flags an error
        next_pslverr = 1'b1;
      end
    endcase
  end

  // one wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      apbRsp <= '0;
    end
    else if (setupPhase)
    begin
      apbRsp.pready <= 1'b1;
      apbRsp.pslverr <= next_pslverr;
      apbRsp.prdata <= apbReq.pwrite ? CCO_WORD_RESET : next_prdata;
    end
    else
    begin
      apbRsp <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // writable registers, restored to defaults by reset

  // heartbeat period in ms, 16 bits, resets to zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      heartbeatPeriod <= CCO_HB_RESET;
    end
    else if (writeCommit && regIndex == CCO_IDX_HB_PERIOD)
    begin
      heartbeatPeriod <= apbReq.pwdata[15:0];
    end
  end

  // sync wrap value; illegal values never reach here
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      syncWrapValue <= CCO_WRAP_RESET;
    end
    else if (writeCommit && regIndex == CCO_IDX_SYNC_WRAP)
    begin
      syncWrapValue <= apbReq.pwdata[7:0];
    end
  end

  // verify record; the master fills it before the save is started
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      storedConfigDate <= CCO_WORD_RESET;
      storedConfigTime <= CCO_WORD_RESET;
    end
    else if (writeCommit && regIndex == CCO_IDX_CFG_DATE)
    begin
      storedConfigDate <= apbReq.pwdata;
    end
    else if (writeCommit && regIndex == CCO_IDX_CFG_TIME)
    begin
      storedConfigTime <= apbReq.pwdata;
    end
  end

  // node guarding control
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      guardEnable <= 1'b0;
      guardTime <= CCO_GUARD_RESET;
    end
    else if (writeCommit && regIndex == CCO_IDX_GUARD_CTRL)
    begin
      guardEnable <= apbReq.pwdata[CCO_GC_EN_BIT];
      guardTime <= apbReq.pwdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick shared by both timers

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      msCount <= 32'h00000000;
      msTick <= 1'b0;
    end
    else if (msCount >= 32'(MS_CYCLES - 1))
    begin
      msCount <= 32'h00000000;
      msTick <= 1'b1;
    end
    else
    begin
      msCount <= msCount + 32'h00000001;
      msTick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // heartbeat producer and node guarding supervision

  assign hbActive = heartbeatPeriod != CCO_HB_RESET;
  // rewriting the period starts a fresh interval
  assign hbRestart = writeCommit && regIndex == CCO_IDX_HB_PERIOD;
  // heartbeat wins: guarding only runs while no heartbeat is produced
  assign guardRun = guardEnable && !hbActive && guardTime != CCO_GUARD_RESET;
  assign guardPeriod = guardRun ? guardTime : CCO_GUARD_RESET;

  cco_interval_timer hbTimer
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(msTick),
    .restart(hbRestart),
    .period(heartbeatPeriod),
    .expire(hbExpire)
  );

  cco_interval_timer guardTimer
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(msTick),
    .restart(guardRequest),
    .period(guardPeriod),
    .expire(guardExpire)
  );

  // request pulses and guarding state to the frame logic
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      hbSend <= 1'b0;
      guardEmcy <= 1'b0;
      guardActive <= 1'b0;
    end
    else
    begin
      hbSend <= hbExpire && hbActive;
      guardEmcy <= guardExpire && guardRun;
      guardActive <= guardRun;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync counter: counts 1..wrap, then starts over; wrap zero leaves it at zero

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      syncCount <= CCO_WRAP_RESET;
    end
    else if (writeCommit && regIndex == CCO_IDX_SYNC_WRAP)
    begin
      syncCount <= CCO_WRAP_RESET;
    end
    else if (syncEvent)
    begin
      if (syncWrapValue == CCO_WRAP_RESET)
      begin
        syncCount <= CCO_WRAP_RESET;
      end
      else if (syncCount >= syncWrapValue)
      begin
        syncCount <= 8'h01;
      end
      else
      begin
        syncCount <= syncCount + 8'h01;
      end
    end
  end

endmodule : cco_comm_objects

// file: verif/cco_comm_objects_sva.sv
// checker for the comm-object bank, seeing only the top ports
// assumes the bus master keeps the APB contract of the bank
`timescale 1ns/1ps
module cco_comm_objects_sva
#(
  parameter int MS_CYCLES = cco_pkg::CCO_MS_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register bus
  input wire cco_pkg::cco_apb_req_s apbReq,
  input wire cco_pkg::cco_apb_rsp_s apbRsp,
  // protocol side
  input wire logic syncEvent,
  input wire logic guardRequest,
  input wire logic hbSend,
  input wire logic guardEmcy,
  input wire logic guardActive,
  input wire logic [7:0] syncCount
);
  import cco_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic wrOk;
  logic [17:0] idx;
  logic [15:0] hbReg;
  logic [7:0] wrapReg;
  logic hadPulse;
  logic pulseOk;
  int gap;
  // access phase, and writes that took effect
  assign acc = apbReq.psel && apbReq.penable && apbRsp.pready;
  assign wrOk = acc && apbReq.pwrite && !apbRsp.pslverr;
  assign idx = apbReq.paddr[19:2];
  assign pulseOk = hbSend && gap > 3;
  // shadow of the settings that drive the outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      hbReg <= CCO_HB_RESET;
    else if (wrOk && idx == CCO_IDX_HB_PERIOD)
      hbReg <= apbReq.pwdata[15:0];
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      wrapReg <= CCO_WRAP_RESET;
    else if (wrOk && idx == CCO_IDX_SYNC_WRAP)
      wrapReg <= apbReq.pwdata[7:0];
  end
  // gap since last pulse; pulses within 3 clocks of a restart are stale
  always_ff @(posedge mclk)
  begin
    if (!rst_b || (wrOk && idx == CCO_IDX_HB_PERIOD))
      gap <= 1;
    else if (pulseOk)
      gap <= 1;
    else
      gap <= gap + 1;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b || (wrOk && idx == CCO_IDX_HB_PERIOD))
      hadPulse <= 1'b0;
    else if (pulseOk)
      hadPulse <= 1'b1;
  end
  ////////////////////////////////////////
  ready_after_setup_a: assert property (apbReq.psel && !apbReq.penable |-> !apbRsp.pready ##1 apbRsp.pready)
    else $error("no single-cycle ready");
  ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready stood too long");
  hb_zero_quiet_a: assert property (hbReg == 0 && $past(hbReg) == 0 && $past(hbReg, 2) == 0 |-> !hbSend)
    else $error("heartbeat with period zero");
  hb_period_a: assert property (hbSend && hadPulse |-> gap == MS_CYCLES * hbReg)
    else $error("heartbeat spacing wrong");
  guard_yield_a: assert property (hbReg != 0 && $past(hbReg) != 0 |-> !guardActive)
    else $error("guarding runs beside heartbeat");
  emcy_quiet_a: assert property (hbReg != 0 && $past(hbReg) != 0 |-> !guardEmcy)
    else $error("guard emcy beside heartbeat");
  sync_step_a: assert property (syncEvent && !acc && wrapReg != 0 && syncCount < wrapReg
    |=> syncCount == $past(syncCount) + 8'h01) else $error("sync count did not step");
  sync_wrap_a: assert property (syncEvent && !acc && wrapReg != 0 && syncCount >= wrapReg
    |=> syncCount == 8'h01) else $error("sync count did not wrap");
  wrap_refuse_a: assert property (acc && apbReq.pwrite && idx == CCO_IDX_SYNC_WRAP
    && (apbReq.pwdata[7:0] == 8'h01 || apbReq.pwdata[7:0] > CCO_WRAP_MAX) |-> apbRsp.pslverr)
    else $error("bad wrap accepted");
  id_readonly_a: assert property (acc && apbReq.pwrite && idx >= CCO_IDX_ID_COUNT
    && idx <= CCO_IDX_SERIAL |-> apbRsp.pslverr) else $error("identity write accepted");
  // a guard request clears the timer, so guardEmcy is low two clocks later
  guard_restart_a: assert property (guardRequest |-> ##2 !guardEmcy)
    else $error("guard emcy right after request");
endmodule : cco_comm_objects_sva
bind cco_comm_objects cco_comm_objects_sva #(.MS_CYCLES(MS_CYCLES)) chk (.mclk(mclk), .rst_b(rst_b),
  .apbReq(apbReq), .apbRsp(apbRsp), .syncEvent(syncEvent), .guardRequest(guardRequest), .hbSend(hbSend),
  .guardEmcy(guardEmcy), .guardActive(guardActive), .syncCount(syncCount));

// file: verif/cco_can_master_model.sv
// stand-in for the bus master: one-clock SYNC and guard-request pulses
// assumes the bench calls its tasks; lines idle low between pulses
`timescale 1ns/1ps
module cco_can_master_model
(
  // clock
  input wire logic mclk,
  // protocol events
  output logic syncEvent,
  output logic guardRequest
);
  initial
  begin
    syncEvent = 1'b0;
    guardRequest = 1'b0;
  end
  // a quiet clock after each pulse so two pulses never merge
  task automatic sendSync();
    @(posedge mclk);
    syncEvent <= 1'b1;
    @(posedge mclk);
    syncEvent <= 1'b0;
    @(posedge mclk);
  endtask : sendSync
  task automatic sendGuard();
    @(posedge mclk);
    guardRequest <= 1'b1;
    @(posedge mclk);
    guardRequest <= 1'b0;
    @(posedge mclk);
  endtask : sendGuard
endmodule : cco_can_master_model

// file: verif/cco_comm_objects_tb.sv
// self-checking bench for the comm-object bank over APB
// assumes MS_CYCLES shortened to 10, so one millisecond is ten clocks
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin fails++; $display("FAIL %0t %h %h", $time, a, b); end end
module cco_comm_objects_tb;
  import cco_pkg::*;
  logic mclk;
  logic rst_b;
  cco_apb_req_s apbReq;
  cco_apb_rsp_s apbRsp;
  logic syncEvent;
  logic guardRequest;
  logic hbSend;
  logic guardEmcy;
  logic guardActive;
  logic [7:0] syncCount;
  logic [31:0] rdata;
  logic err;
  int fails = 0;
  int nChecks = 0;
  int cycles = 0;
  int hbCount = 0;
  int emcyCount = 0;
  cco_comm_objects #(.MS_CYCLES(10)) uut (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
    .syncEvent(syncEvent), .guardRequest(guardRequest), .hbSend(hbSend), .guardEmcy(guardEmcy),
    .guardActive(guardActive), .syncCount(syncCount));
  cco_can_master_model master (.mclk(mclk), .syncEvent(syncEvent), .guardRequest(guardRequest));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // pulse counters and hang limit
  always @(posedge mclk)
  begin
    cycles++;
    if (hbSend === 1'b1) hbCount++;
    if (guardEmcy === 1'b1) emcyCount++;
    if (cycles == 3000)
    begin
      fails++;
      endSim();
    end
  end
  ////////////////////////////////////////
  // one APB transfer; held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wdata);
    int n;
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wdata};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    n = 0;
    // no wait limit here: only the bench timeout ends a stuck access
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (apbRsp.pready !== 1'b1);
    // the bank answers with no wait state
    `CHK(n, 1)
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic rdChk(input logic [17:0] idx, input logic [31:0] exp, input logic expErr);
    apb(1'b0, idx, 32'h00000000);
    `CHK(rdata, exp)
    `CHK(err, expErr)
  endtask : rdChk
  task automatic wrChk(input logic [17:0] idx, input logic [31:0] data, input logic expErr);
    apb(1'b1, idx, data);
    `CHK(err, expErr)
  endtask : wrChk
  task automatic endSim();
    if (fails == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : endSim
  ////////////////////////////////////////
  initial
  begin
    apbReq = '0;
    rst_b = 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    // defaults, identity words, read-only places, an unmapped index
    rdChk(CCO_IDX_HB_PERIOD, 32'h00000000, 1'b0);
    rdChk(CCO_IDX_SYNC_WRAP, 32'h00000000, 1'b0);
    rdChk(CCO_IDX_ID_COUNT, 32'h00000004, 1'b0);
    rdChk(CCO_IDX_MAKER, CCO_MAKER_DEF, 1'b0);
    rdChk(CCO_IDX_PRODUCT, CCO_PRODUCT_DEF, 1'b0);
    rdChk(CCO_IDX_REVISION, CCO_REVISION_DEF, 1'b0);
    rdChk(CCO_IDX_SERIAL, CCO_SERIAL_DEF, 1'b0);
    rdChk(CCO_IDX_VFY_COUNT, 32'h00000002, 1'b0);
    rdChk(CCO_IDX_CFG_DATE, 32'h00000000, 1'b0);
    rdChk(CCO_IDX_CFG_TIME, 32'h00000000, 1'b0);
    rdChk(18'h00FFF, 32'h00000000, 1'b1);
    wrChk(CCO_IDX_ID_COUNT, 32'h00000009, 1'b1);
    wrChk(CCO_IDX_MAKER, 32'h12345678, 1'b1);
    rdChk(CCO_IDX_MAKER, CCO_MAKER_DEF, 1'b0);
    // date then time, as a master does before a save
    wrChk(CCO_IDX_CFG_DATE, 32'h00003A2B, 1'b0);
    wrChk(CCO_IDX_CFG_TIME, 32'h0202FBF0, 1'b0);
    rdChk(CCO_IDX_CFG_DATE, 32'h00003A2B, 1'b0);
    rdChk(CCO_IDX_CFG_TIME, 32'h0202FBF0, 1'b0);
    // wrap limits, then a wrap of two runs 1, 2, 1, 2
    wrChk(CCO_IDX_SYNC_WRAP, 32'h00000001, 1'b1);
    wrChk(CCO_IDX_SYNC_WRAP, 32'h000000F1, 1'b1);
    wrChk(CCO_IDX_SYNC_WRAP, 32'h000000F0, 1'b0);
    wrChk(CCO_IDX_SYNC_WRAP, 32'h00000002, 1'b0);
    rdChk(CCO_IDX_SYNC_WRAP, 32'h00000002, 1'b0);
    for (int i = 1; i <= 4; i++)
    begin
      master.sendSync();
      `CHK(syncCount, (i % 2 == 0) ? 8'h02 : 8'h01)
    end
    wrChk(CCO_IDX_SYNC_WRAP, 32'h00000000, 1'b0);
    master.sendSync();
    `CHK(syncCount, 8'h00)
    // two ms period: pulses at about 12, 32, 52, 72 clocks
    wrChk(CCO_IDX_HB_PERIOD, 32'h00000002, 1'b0);
    repeat (90) @(posedge mclk);
    `CHK(hbCount, 4)
    wrChk(CCO_IDX_GUARD_CTRL, 32'h00010001, 1'b0);
    repeat (40) @(posedge mclk);
    `CHK(guardActive, 1'b0)
    `CHK(emcyCount, 0)
    wrChk(CCO_IDX_HB_PERIOD, 32'h00000000, 1'b0);
    hbCount = 0;
    repeat (3) @(posedge mclk);
    `CHK(guardActive, 1'b1)
    emcyCount = 0;
    repeat (4) master.sendGuard();
    `CHK(emcyCount, 0)
    repeat (30) @(posedge mclk);
    `CHK(emcyCount != 0, 1'b1)
    `CHK(hbCount, 0)
    // status and guard control read back, remaining read-only places
    rdChk(CCO_IDX_STATUS, 32'h00000001 << CCO_ST_GUARD_BIT, 1'b0);
    rdChk(CCO_IDX_GUARD_CTRL, 32'h00010001, 1'b0);
    wrChk(CCO_IDX_STATUS, 32'h00000000, 1'b1);
    wrChk(CCO_IDX_PRODUCT, 32'h00000000, 1'b1);
    wrChk(CCO_IDX_REVISION, 32'h00000000, 1'b1);
    wrChk(CCO_IDX_SERIAL, 32'h00000001, 1'b1);
    wrChk(CCO_IDX_VFY_COUNT, 32'h00000005, 1'b1);
    rdChk(CCO_IDX_VFY_COUNT, 32'h00000002, 1'b0);
    // upper bits of narrow registers are dropped and read zero
    wrChk(CCO_IDX_SYNC_WRAP, 32'hFFFFFF02, 1'b0);
    rdChk(CCO_IDX_SYNC_WRAP, 32'h00000002, 1'b0);
    wrChk(CCO_IDX_HB_PERIOD, 32'hABCD1234, 1'b0);
    rdChk(CCO_IDX_HB_PERIOD, 32'h00001234, 1'b0);
    rdChk(CCO_IDX_STATUS, 32'h00000001 << CCO_ST_HB_BIT, 1'b0);
    // a restart in mid-run brings back every default
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdChk(CCO_IDX_HB_PERIOD, 32'h00000000, 1'b0);
    rdChk(CCO_IDX_SYNC_WRAP, 32'h00000000, 1'b0);
    rdChk(CCO_IDX_CFG_DATE, 32'h00000000, 1'b0);
    `CHK(guardActive, 1'b0)
    endSim();
  end
endmodule : cco_comm_objects_tb
